/* inc/bpf_pkg.sv */
package bpf_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int REG_ADDR_W  = 4;
  localparam int REG_DATA_W  = 8;
  localparam int PORT_W      = 8;
  localparam int PIN_COUNT   = 25;
  localparam int BUS_ADDR_W  = 24;
  localparam int BUS_DATA_W  = 16;
  localparam int PPG_COUNT   = 4;

  // ---------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [REG_ADDR_W-1:0] REG_PORT0_DATA = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_PORT0_DIR  = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_PORT1_DATA = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_PORT1_DIR  = 4'h3;
  localparam logic [REG_ADDR_W-1:0] REG_PORT2_DATA = 4'h4;
  localparam logic [REG_ADDR_W-1:0] REG_PORT2_DIR  = 4'h5;
  localparam logic [REG_ADDR_W-1:0] REG_PORT3_DATA = 4'h6;
  localparam logic [REG_ADDR_W-1:0] REG_PORT3_DIR  = 4'h7;
  localparam logic [REG_ADDR_W-1:0] REG_PULLUP0    = 4'h8;
  localparam logic [REG_ADDR_W-1:0] REG_PULLUP1    = 4'h9;
  localparam logic [REG_ADDR_W-1:0] REG_HADDR_CTRL = 4'hA;
  localparam logic [REG_ADDR_W-1:0] REG_BUS_MODE   = 4'hB;
  localparam logic [REG_ADDR_W-1:0] REG_PPG_ENABLE = 4'hC;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [PORT_W-1:0]     PORT_RESET      = 8'h00;
  localparam logic [PORT_W-1:0]     HADDR_RESET     = 8'h00;
  localparam logic [PPG_COUNT-1:0]  PPG_RESET       = 4'h0;
  localparam logic [REG_DATA_W-1:0] READ_UNMAPPED   = 8'h00;
  localparam int                    MODE_LSB        = 0;
  localparam int                    PORT0_BASE      = 0;
  localparam int                    PORT1_BASE      = 8;
  localparam int                    PORT2_BASE      = 16;
  localparam int                    PORT3_BASE      = 24;
  localparam int                    ADDR_LOW_LSB    = 0;
  localparam int                    ADDR_HIGH_LSB   = 8;
  localparam int                    ADDR_16_LSB     = 16;
  localparam int                    PPG_PIN_LSB     = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_MUX,
    MODE_NONMUX
  } bpf_mode_e;

  localparam bpf_mode_e MODE_RESET = MODE_SINGLE;

  // Core-side external bus request
  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [BUS_DATA_W-1:0] wdata;
    logic                  dataOe;
    logic                  addrPhase;
  } bpf_bus_s;

endpackage : bpf_pkg

/* verif/bpf_ext_mem.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// External memory on the sixteen data lanes
// ---------------------------------------------------------------
module bpf_ext_mem (
  // Clock
  input  wire logic        clk,
  // Device side of the lanes
  input  wire logic [15:0] laneOut,
  input  wire logic [15:0] laneOe,
  input  wire logic [15:0] lanePullup,
  // Answer control from the bench
  input  wire logic        memDrive,
  input  wire logic [15:0] memData,
  input  wire logic [1:0]  memDelay,
  // Resolved lane levels
  output logic      [15:0] laneIn
);
  logic [15:0] lastLevel_reg = 16'h0000;
  logic [1:0]  idleCount_reg = 2'h0;
  // Cycles since the device let go of every lane, so slow answers can be made
  always_ff @(posedge clk) begin
    if ((|laneOe) || !memDrive) idleCount_reg <= 2'h0;
    else if (idleCount_reg != 2'h3) idleCount_reg <= idleCount_reg + 2'h1;
  end
  // A floating lane never keeps its old level: it toggles unless pulled up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (laneOe[i]) laneIn[i] = laneOut[i];
      else if (memDrive && (idleCount_reg >= memDelay)) laneIn[i] = memData[i];
      else if (lanePullup[i]) laneIn[i] = 1'b1;
      else laneIn[i] = ~lastLevel_reg[i];
    end
  end
  // Last resolved level
  always_ff @(posedge clk) lastLevel_reg <= laneIn;
endmodule : bpf_ext_mem

/* verif/tb_bus_port_pin_function_select.sv */
`timescale 1ns/10ps
module tb_bus_port_pin_function_select;
  import bpf_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic            clk, rst, regWrite, regRead, memDrive, cntIn;
  logic [3:0]      regAddr, pulse;
  logic [7:0]      regWdata, regRdata;
  logic [7:0]      p0Out, p0Oe, p0Pu, p1Out, p1Oe, p1Pu, p2Out, p2Oe, p2In;
  logic            p3Out, p3Oe, p3In, cntA;
  logic [15:0]     busRdata, memData, laneIn;
  logic [1:0]      memDelay;
  bpf_bus_s        busReq;
  int              n_errors = 0;
  int              n_compared = 0;
  // Released port 2 and port 3 lines read back inverted or from the counter source
  assign p2In = (p2Oe & p2Out) | (~p2Oe & ~p2Out);
  assign p3In = p3Oe ? p3Out : cntIn;
  bpf_pin_mux uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .busReq(busReq),
    .busRdata(busRdata), .pulseGenOutputs(pulse), .updownCounter0InputA(cntA),
    .port0PinsIn(laneIn[7:0]), .port0PinsOut(p0Out), .port0PinsOe(p0Oe),
    .port0PullupEn(p0Pu), .port1PinsIn(laneIn[15:8]), .port1PinsOut(p1Out),
    .port1PinsOe(p1Oe), .port1PullupEn(p1Pu), .port2PinsIn(p2In), .port2PinsOut(p2Out),
    .port2PinsOe(p2Oe), .port3Pin0In(p3In), .port3Pin0Out(p3Out), .port3Pin0Oe(p3Oe));
  bpf_ext_mem mem (.clk(clk), .laneOut({p1Out, p0Out}), .laneOe({p1Oe, p0Oe}),
    .lanePullup({p1Pu, p0Pu}), .memDrive(memDrive), .memData(memData),
    .memDelay(memDelay), .laneIn(laneIn));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(24'(regRdata), 24'(e));
  endtask : rd
  // Long enough for pad flops, the two-flop sync and a slow memory answer
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic bus(input logic [23:0] a, input logic [15:0] w, input logic oe, ph);
    @(posedge clk);
    busReq <= '{a, w, oe, ph};
    settle;
  endtask : bus
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(24'({p0Oe, p1Oe, p2Oe}), 24'h0);
    chk(24'({p0Pu, p1Pu, p3Oe}), 24'h0);
    rd(REG_PULLUP0, 8'h00);
  endtask : t_reset
  task automatic t_pullup;
    wr(REG_PULLUP0, 8'hA5);
    wr(REG_PULLUP1, 8'h3C);
    wr(REG_PORT0_DIR, 8'h0F);
    settle;
    chk(24'(p0Pu), 24'hA0);
    chk(24'(p1Pu), 24'h3C);
    wr(REG_PORT1_DIR, 8'hFF);
    settle;
    chk(24'(p1Pu), 24'h00);
    rd(REG_PULLUP1, 8'h3C);
    rd(4'hF, READ_UNMAPPED);
  endtask : t_pullup
  task automatic t_gpio;
    wr(REG_PORT0_DATA, 8'h5A);
    wr(REG_PORT0_DIR, 8'hFF);
    wr(REG_PORT2_DATA, 8'hC3);
    wr(REG_PORT2_DIR, 8'hFF);
    wr(REG_PORT3_DATA, 8'h01);
    wr(REG_PORT3_DIR, 8'h01);
    settle;
    chk(24'({p0Oe, p0Out}), 24'hFF5A);
    chk(24'({p2Oe, p2Out}), 24'hFFC3);
    chk(24'({p3Oe, p3Out}), 24'h3);
    rd(REG_PORT0_DATA, 8'h5A);
  endtask : t_gpio
  task automatic t_mux;
    wr(REG_HADDR_CTRL, 8'h00);
    wr(REG_BUS_MODE, 8'h01);
    bus(24'hABCDEF, 16'h0, 1'b0, 1'b1);
    chk(24'({p1Oe, p0Oe, p1Out}), 24'hFFFFCD);
    chk(24'(p0Out), 24'hEF);
    chk(24'({p2Oe, p2Out}), 24'hFFAB);
    bus(24'hABCDEF, 16'h1234, 1'b1, 1'b0);
    chk(24'({p1Out, p0Out}), 24'h1234);
    memDelay = 2'h1;
    memData  = 16'h5678;
    memDrive = 1'b1;
    bus(24'hABCDEF, 16'h0, 1'b0, 1'b0);
    chk(24'({p1Oe, p0Oe}), 24'h0);
    chk(24'(busRdata), 24'h5678);
  endtask : t_mux
  task automatic t_nonmux;
    memDrive = 1'b0;
    wr(REG_HADDR_CTRL, 8'hF1);
    wr(REG_BUS_MODE, 8'h02);
    bus(24'h9A0001, 16'h0, 1'b0, 1'b0);
    chk(24'({p2Oe, p2Out}), 24'hFFCB);
    chk(24'({p3Oe, p3Out}), 24'h3);
    bus(24'h9A0000, 16'hBEEF, 1'b1, 1'b0);
    chk(24'({p1Out, p0Out}), 24'hBEEF);
    chk(24'({p1Oe, p0Oe}), 24'hFFFF);
    chk(24'({p3Oe, p3Out}), 24'h2);
    memDelay = 2'h0;
    memData  = 16'hA55A;
    memDrive = 1'b1;
    bus(24'h9A0000, 16'h0, 1'b0, 1'b0);
    chk(24'(busRdata), 24'hA55A);
    wr(REG_BUS_MODE, 8'h03);
    rd(REG_BUS_MODE, 8'h02);
  endtask : t_nonmux
  task automatic t_ppg;
    wr(REG_BUS_MODE, 8'h00);
    wr(REG_PPG_ENABLE, 8'h0F);
    wr(REG_PORT3_DIR, 8'h00);
    @(posedge clk);
    pulse <= 4'h9;
    cntIn <= 1'b1;
    settle;
    chk(24'({p2Oe, p2Out}), 24'hFF93);
    chk(24'({p3Oe, cntA}), 24'h1);
    @(posedge clk);
    cntIn <= 1'b0;
    wr(REG_PPG_ENABLE, 8'h00);
    settle;
    chk(24'({p2Oe, p2Out, 7'h0, cntA}), 24'hFFC300);
  endtask : t_ppg
  // ---------------------------------------------------------------
  // Clock, sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {regAddr, regWdata, regWrite, regRead, pulse, cntIn} = '0;
    {memDrive, memData, memDelay} = '0;
    busReq = '0;
    rst    = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_pullup;
    t_gpio;
    t_mux;
    t_nonmux;
    t_ppg;
    report_and_stop;
  end
  // The whole run needs well under a thousand cycles
  initial begin
    #50000;
    n_errors++;
    report_and_stop;
  end
endmodule : tb_bus_port_pin_function_select

/* verilog/bpf_pin_cell.sv */
`timescale 1ns/10ps
// Registered pad cell: output, enable and pull-up flops plus input synchroniser
module bpf_pin_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Selected function
  input  wire logic outNext,
  input  wire logic oeNext,
  input  wire logic puNext,
  // Pad
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe,
  output logic      pullupEn,
  // Synchronised pad level
  output logic      inSync
);

  logic syncFirst_reg;

  // ---------------------------------------------------------------
  // Output side
  // ---------------------------------------------------------------
  // Registered so the pad never sees a mux glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut   <= 1'b0;
      pinOe    <= 1'b0;
      pullupEn <= 1'b0;
    end else begin
      pinOut   <= outNext;
      pinOe    <= oeNext;
      pullupEn <= puNext;
    end
  end

  // ---------------------------------------------------------------
  // Input side
  // ---------------------------------------------------------------
  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncFirst_reg <= 1'b0;
      inSync        <= 1'b0;
    end else begin
      syncFirst_reg <= pinIn;
      inSync        <= syncFirst_reg;
    end
  end

endmodule : bpf_pin_cell

/* verilog/bpf_pin_mux.sv */
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
// Operation
// - Port 0 pin gets pull-up when its port 0 pull-up bit is 1.
// - Port 1 pin gets pull-up when its port 1 pull-up bit is 1.
// - Pull-up is removed from any pin whose direction is output; only the direction bit masks it here, so bus drive leaves it on.
// - Multiplexed mode: port 0 is the bidirectional low address/data byte.
// - Non-multiplexed mode: port 0 drives the low data byte.
// - Multiplexed mode: port 1 is the bidirectional high address/data byte.
// - Non-multiplexed mode: port 1 drives the high data byte.
// - Bus mode: port 2 pin is plain I/O when its address control bit is 1.
// - Bus mode: port 2 low pins drive address 16..19 when control bit 0.
// - Bus mode: port 2 high pins drive address 20..23 when control bit 0.
// - Port 2 high pins can carry pulse-generator outputs 0 to 3.
// - Port 3 pin 0 drives address bit 0 in non-multiplexed mode, else I/O.
// - Port 3 pin 0 feeds up/down counter 0 input A.
module bpf_pin_mux (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Register port
  input  wire logic [bpf_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [bpf_pkg::REG_DATA_W-1:0] regWdata,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  output logic      [bpf_pkg::REG_DATA_W-1:0] regRdata,
  // Core external bus and peripherals
  input  wire bpf_pkg::bpf_bus_s              busReq,
  output logic      [bpf_pkg::BUS_DATA_W-1:0] busRdata,
  input  wire logic [bpf_pkg::PPG_COUNT-1:0]  pulseGenOutputs,
  output logic                                updownCounter0InputA,
  // Port 0 pins
  input  wire logic [bpf_pkg::PORT_W-1:0]     port0PinsIn,
  output logic      [bpf_pkg::PORT_W-1:0]     port0PinsOut,
  output logic      [bpf_pkg::PORT_W-1:0]     port0PinsOe,
  output logic      [bpf_pkg::PORT_W-1:0]     port0PullupEn,
  // Port 1 pins
  input  wire logic [bpf_pkg::PORT_W-1:0]     port1PinsIn,
  output logic      [bpf_pkg::PORT_W-1:0]     port1PinsOut,
  output logic      [bpf_pkg::PORT_W-1:0]     port1PinsOe,
  output logic      [bpf_pkg::PORT_W-1:0]     port1PullupEn,
  // Port 2 pins
  input  wire logic [bpf_pkg::PORT_W-1:0]     port2PinsIn,
  output logic      [bpf_pkg::PORT_W-1:0]     port2PinsOut,
  output logic      [bpf_pkg::PORT_W-1:0]     port2PinsOe,
  // Port 3 pin 0
  input  wire logic                           port3Pin0In,
  output logic                                port3Pin0Out,
  output logic                                port3Pin0Oe
);
  import bpf_pkg::*;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [PORT_W-1:0]    data0_reg;
  logic [PORT_W-1:0]    dir0_reg;
  logic [PORT_W-1:0]    data1_reg;
  logic [PORT_W-1:0]    dir1_reg;
  logic [PORT_W-1:0]    data2_reg;
  logic [PORT_W-1:0]    dir2_reg;
  logic                 data3_reg;
  logic                 dir3_reg;
  logic [PORT_W-1:0]    pullup0_reg;
  logic [PORT_W-1:0]    pullup1_reg;
  logic [PORT_W-1:0]    haddrCtrl_reg;
  bpf_mode_e            mode_reg;
  logic [PPG_COUNT-1:0] ppgEn_reg;

  logic [PIN_COUNT-1:0] outNext;
  logic [PIN_COUNT-1:0] oeNext;
  logic [PIN_COUNT-1:0] puNext;
  logic [PIN_COUNT-1:0] pinIn;
  logic [PIN_COUNT-1:0] pinOut;
  logic [PIN_COUNT-1:0] pinOe;
  logic [PIN_COUNT-1:0] pullupEn;
  logic [PIN_COUNT-1:0] inSync;
  logic                 busMode;
  logic                 modeLegal;

  assign busMode   = (mode_reg != MODE_SINGLE);
  assign modeLegal = (regWdata[MODE_LSB +: 2] != 2'h3);

  // Port data and direction registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data0_reg <= PORT_RESET;
      dir0_reg  <= PORT_RESET;
      data1_reg <= PORT_RESET;
      dir1_reg  <= PORT_RESET;
      data2_reg <= PORT_RESET;
      dir2_reg  <= PORT_RESET;
      data3_reg <= 1'b0;
      dir3_reg  <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        REG_PORT0_DATA: data0_reg <= regWdata;
        REG_PORT0_DIR:  dir0_reg  <= regWdata;
        REG_PORT1_DATA: data1_reg <= regWdata;
        REG_PORT1_DIR:  dir1_reg  <= regWdata;
        REG_PORT2_DATA: data2_reg <= regWdata;
        REG_PORT2_DIR:  dir2_reg  <= regWdata;
        REG_PORT3_DATA: data3_reg <= regWdata[0];
        REG_PORT3_DIR:  dir3_reg  <= regWdata[0];
        default: begin
        end
      endcase
    end
  end

  // Function select registers; an unused mode code is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pullup0_reg   <= PORT_RESET;
      pullup1_reg   <= PORT_RESET;
      haddrCtrl_reg <= HADDR_RESET;
      mode_reg      <= MODE_RESET;
      ppgEn_reg     <= PPG_RESET;
    end else if (regWrite) begin
      case (regAddr)
        REG_PULLUP0:    pullup0_reg   <= regWdata;
        REG_PULLUP1:    pullup1_reg   <= regWdata;
        REG_HADDR_CTRL: haddrCtrl_reg <= regWdata;
        REG_BUS_MODE: begin
          if (modeLegal) begin
            mode_reg <= bpf_mode_e'(regWdata[MODE_LSB +: 2]);
          end
        end
        REG_PPG_ENABLE: ppgEn_reg     <= regWdata[PPG_COUNT-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; data
  // registers read back the synchronised pin level, not the latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= READ_UNMAPPED;
    end else if (regRead) begin
      case (regAddr)
        REG_PORT0_DATA: regRdata <= inSync[PORT0_BASE +: PORT_W];
        REG_PORT0_DIR:  regRdata <= dir0_reg;
        REG_PORT1_DATA: regRdata <= inSync[PORT1_BASE +: PORT_W];
        REG_PORT1_DIR:  regRdata <= dir1_reg;
        REG_PORT2_DATA: regRdata <= inSync[PORT2_BASE +: PORT_W];
        REG_PORT2_DIR:  regRdata <= dir2_reg;
        REG_PORT3_DATA: regRdata <= {7'h00, inSync[PORT3_BASE]};
        REG_PORT3_DIR:  regRdata <= {7'h00, dir3_reg};
        REG_PULLUP0:    regRdata <= pullup0_reg;
        REG_PULLUP1:    regRdata <= pullup1_reg;
        REG_HADDR_CTRL: regRdata <= haddrCtrl_reg;
        REG_BUS_MODE:   regRdata <= {6'h00, mode_reg};
        REG_PPG_ENABLE: regRdata <= {4'h0, ppgEn_reg};
        default:        regRdata <= READ_UNMAPPED;
      endcase
    end else begin
      regRdata <= READ_UNMAPPED;
    end
  end

  // ---------------------------------------------------------------
  // Function select
  // ---------------------------------------------------------------
  // One process drives every select vector: split processes would
  // each claim the whole vector and clash as rival drivers
  always_comb begin
    // Ports 0 and 1: bus byte lanes or plain I/O
    for (int i = 0; i < PORT_W; i++) begin
      case (mode_reg)
        MODE_MUX: begin
          // Address phase drives address, then data on writes only
          outNext[PORT0_BASE+i] = busReq.addrPhase ? busReq.addr[ADDR_LOW_LSB+i]
                                                   : busReq.wdata[ADDR_LOW_LSB+i];
          oeNext[PORT0_BASE+i]  = busReq.addrPhase | busReq.dataOe;
          outNext[PORT1_BASE+i] = busReq.addrPhase ? busReq.addr[ADDR_HIGH_LSB+i]
                                                   : busReq.wdata[ADDR_HIGH_LSB+i];
          oeNext[PORT1_BASE+i]  = busReq.addrPhase | busReq.dataOe;
        end
        MODE_NONMUX: begin
          outNext[PORT0_BASE+i] = busReq.wdata[ADDR_LOW_LSB+i];
          oeNext[PORT0_BASE+i]  = busReq.dataOe;
          outNext[PORT1_BASE+i] = busReq.wdata[ADDR_HIGH_LSB+i];
          oeNext[PORT1_BASE+i]  = busReq.dataOe;
        end
        default: begin
          outNext[PORT0_BASE+i] = data0_reg[i];
          oeNext[PORT0_BASE+i]  = dir0_reg[i];
          outNext[PORT1_BASE+i] = data1_reg[i];
          oeNext[PORT1_BASE+i]  = dir1_reg[i];
        end
      endcase
      // Pull-up follows its bit, masked by the direction bit only, so bus drive leaves it on
      puNext[PORT0_BASE+i] = pullup0_reg[i] & ~dir0_reg[i];
      puNext[PORT1_BASE+i] = pullup1_reg[i] & ~dir1_reg[i];
      puNext[PORT2_BASE+i] = 1'b0;
    end

    // Port 2: high address, pulse-generator outputs or plain I/O
    for (int i = 0; i < PORT_W; i++) begin
      if (busMode && !haddrCtrl_reg[i]) begin
        outNext[PORT2_BASE+i] = busReq.addr[ADDR_16_LSB+i];
        oeNext[PORT2_BASE+i]  = 1'b1;
      end else if (i >= PPG_PIN_LSB && ppgEn_reg[(i - PPG_PIN_LSB) % PPG_COUNT]) begin
        outNext[PORT2_BASE+i] = pulseGenOutputs[(i - PPG_PIN_LSB) % PPG_COUNT];
        oeNext[PORT2_BASE+i]  = 1'b1;
      end else begin
        outNext[PORT2_BASE+i] = data2_reg[i];
        oeNext[PORT2_BASE+i]  = dir2_reg[i];
      end
    end

    // Port 3 pin 0: address bit 0 only when the bus is not multiplexed
    if (mode_reg == MODE_NONMUX) begin
      outNext[PORT3_BASE] = busReq.addr[ADDR_LOW_LSB];
      oeNext[PORT3_BASE]  = 1'b1;
    end else begin
      outNext[PORT3_BASE] = data3_reg;
      oeNext[PORT3_BASE]  = dir3_reg;
    end
    puNext[PORT3_BASE] = 1'b0;
  end

  // ---------------------------------------------------------------
  // Pad cells
  // ---------------------------------------------------------------
  assign pinIn = {port3Pin0In, port2PinsIn, port1PinsIn, port0PinsIn};

  generate
    for (genvar g = 0; g < PIN_COUNT; g++) begin : gPin
      bpf_pin_cell uCell (
        .clk      (clk),
        .rst      (rst),
        .outNext  (outNext[g]),
        .oeNext   (oeNext[g]),
        .puNext   (puNext[g]),
        .pinIn    (pinIn[g]),
        .pinOut   (pinOut[g]),
        .pinOe    (pinOe[g]),
        .pullupEn (pullupEn[g]),
        .inSync   (inSync[g])
      );
    end
  endgenerate

  // Every pad output below is a flop inside its cell
  assign port0PinsOut  = pinOut[PORT0_BASE +: PORT_W];
  assign port0PinsOe   = pinOe[PORT0_BASE +: PORT_W];
  assign port0PullupEn = pullupEn[PORT0_BASE +: PORT_W];
  assign port1PinsOut  = pinOut[PORT1_BASE +: PORT_W];
  assign port1PinsOe   = pinOe[PORT1_BASE +: PORT_W];
  assign port1PullupEn = pullupEn[PORT1_BASE +: PORT_W];
  assign port2PinsOut  = pinOut[PORT2_BASE +: PORT_W];
  assign port2PinsOe   = pinOe[PORT2_BASE +: PORT_W];
  assign port3Pin0Out  = pinOut[PORT3_BASE];
  assign port3Pin0Oe   = pinOe[PORT3_BASE];

  // Bus read data and counter input come straight off the synchronisers;
  // the core must allow two cycles of input latency
  assign busRdata             = inSync[PORT0_BASE +: BUS_DATA_W];
  assign updownCounter0InputA = inSync[PORT3_BASE];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cbAssert @(posedge clk); endclocking
  default disable iff (rst);

  a_pullup0_follow: assert property (
    ##1 port0PullupEn == $past(pullup0_reg & ~dir0_reg))
    else $error("port 0 pull-up does not follow its select bits");
  a_pullup1_follow: assert property (
    ##1 port1PullupEn == $past(pullup1_reg & ~dir1_reg))
    else $error("port 1 pull-up does not follow its select bits");
  a_pullup_output_off: assert property (
    dir0_reg[0] && dir1_reg[0] |=> !port0PullupEn[0] && !port1PullupEn[0])
    else $error("pull-up left on an output pin");
  a_mux_low_addr: assert property (
    mode_reg == MODE_MUX && busReq.addrPhase
      |=> port0PinsOe == 8'hFF && port0PinsOut == $past(busReq.addr[7:0]))
    else $error("muxed low byte does not carry the address");
  a_nonmux_low_data: assert property (
    mode_reg == MODE_NONMUX && busReq.dataOe
      |=> port0PinsOe == 8'hFF && port0PinsOut == $past(busReq.wdata[7:0]))
    else $error("non-muxed low data byte not driven");
  a_mux_high_release: assert property (
    mode_reg == MODE_MUX && !busReq.addrPhase && !busReq.dataOe
      |=> port1PinsOe == 8'h00)
    else $error("muxed high byte not released for a read");
  a_nonmux_high_data: assert property (
    mode_reg == MODE_NONMUX && busReq.dataOe
      |=> port1PinsOut == $past(busReq.wdata[15:8]))
    else $error("non-muxed high data byte wrong");
  a_haddr_gpio_pin: assert property (
    busMode && haddrCtrl_reg[0] |=> port2PinsOe[0] == $past(dir2_reg[0]))
    else $error("port 2 pin not plain I/O under its control bit");
  a_addr16_drive: assert property (
    busMode && !haddrCtrl_reg[0]
      |=> port2PinsOe[0] && port2PinsOut[0] == $past(busReq.addr[16]))
    else $error("address bit 16 not driven");
  a_addr23_drive: assert property (
    busMode && !haddrCtrl_reg[7] |=> port2PinsOut[7] == $past(busReq.addr[23]))
    else $error("address bit 23 not driven");
  a_pulse_gen_out: assert property (
    !busMode && ppgEn_reg[0]
      |=> port2PinsOe[4] && port2PinsOut[4] == $past(pulseGenOutputs[0]))
    else $error("pulse-generator 0 not on its pin");
  a_addr0_drive: assert property (
    mode_reg == MODE_NONMUX |=> port3Pin0Oe && port3Pin0Out == $past(busReq.addr[0]))
    else $error("address bit 0 not driven");
  a_counter_input: assert property (
    ##2 updownCounter0InputA == $past(port3Pin0In, 2))
    else $error("counter input not two cycles behind the pin");
  a_gpio_default: assert property (
    mode_reg == MODE_SINGLE && ppgEn_reg == 4'h0
      |=> port2PinsOut == $past(data2_reg) && port2PinsOe == $past(dir2_reg))
    else $error("idle port 2 pins ignore data or direction");

  // Second lane, write data and release checks
  a_mux_high_addr: assert property (
    mode_reg == MODE_MUX && busReq.addrPhase
      |=> port1PinsOe == 8'hFF && port1PinsOut == $past(busReq.addr[15:8]))
    else $error("muxed high byte does not carry the address");
  a_mux_low_data: assert property (
    mode_reg == MODE_MUX && !busReq.addrPhase && busReq.dataOe
      |=> port0PinsOe == 8'hFF && port0PinsOut == $past(busReq.wdata[7:0]))
    else $error("muxed low byte does not carry write data");
  a_nonmux_low_release: assert property (
    mode_reg == MODE_NONMUX && !busReq.dataOe |=> port0PinsOe == 8'h00)
    else $error("non-muxed low byte still driven during a read");
  a_addr20_drive: assert property (
    busMode && !haddrCtrl_reg[4]
      |=> port2PinsOe[4] && port2PinsOut[4] == $past(busReq.addr[20]))
    else $error("address bit 20 not driven");
  a_pulse_gen_high: assert property (
    !busMode && ppgEn_reg[3]
      |=> port2PinsOe[7] && port2PinsOut[7] == $past(pulseGenOutputs[3]))
    else $error("pulse-generator 3 not on its pin");
  a_addr0_release: assert property (
    mode_reg != MODE_NONMUX
      |=> port3Pin0Oe == $past(dir3_reg) && port3Pin0Out == $past(data3_reg))
    else $error("port 3 pin 0 not plain I/O outside non-muxed mode");

  c_mux_write: cover property (mode_reg == MODE_MUX && busReq.addrPhase ##1 busReq.dataOe);
  c_haddr_split: cover property (busMode && haddrCtrl_reg != 8'h00 && haddrCtrl_reg != 8'hFF);
  c_nonmux_write: cover property (mode_reg == MODE_NONMUX && busReq.dataOe);
  c_ppg_active: cover property (!busMode && ppgEn_reg == 4'hF);
  c_pullup_on: cover property (port0PullupEn != 8'h00 && port1PullupEn != 8'h00);

endmodule : bpf_pin_mux
